//--- hdl/sbcd_conv_pkg.sv
// Package: register map, operation codes, format limits and carrier types of the signed BCD converter
`default_nettype none
package sbcd_conv_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] adr_opcode = 8'h00;
   localparam logic [7:0] adr_format = 8'h04;
   localparam logic [7:0] adr_src_lo = 8'h08;
   localparam logic [7:0] adr_src_hi = 8'h0c;
   localparam logic [7:0] adr_res_lo = 8'h10;
   localparam logic [7:0] adr_res_hi = 8'h14;
   localparam logic [7:0] adr_status = 8'h18;
   localparam logic [7:0] adr_start  = 8'h1c;

   // Status register bit positions
   localparam int sts_done_bit  = 0;
   localparam int sts_error_bit = 1;
   localparam int sts_equal_bit = 2;
   localparam int sts_neg_bit   = 3;
   localparam int sts_busy_bit  = 4;

   // Operation codes, decimal 470 to 473
   localparam logic [15:0] op_bcd_to_bin_single = 16'h01d6;
   localparam logic [15:0] op_bin_to_bcd_single = 16'h01d7;
   localparam logic [15:0] op_bcd_to_bin_double = 16'h01d8;
   localparam logic [15:0] op_bin_to_bcd_double = 16'h01d9;

   // Reset values
   localparam logic [15:0] word_reset = 16'h0000;
   localparam logic [31:0] bus_reset  = 32'h0000_0000;

   // Highest legal format selector
   localparam logic [15:0] format_max = 16'h0003;

   // Binary windows per format, index is the format selector
   localparam logic [3:0][31:0] single_min = {32'hffff_f831, 32'hffff_fc19, 32'hffff_e0c1, 32'hffff_fc19};
   localparam logic [3:0][31:0] single_max = {32'h0000_270f, 32'h0000_270f, 32'h0000_1f3f, 32'h0000_03e7};
   localparam logic [3:0][31:0] double_min = {32'hfece_d301, 32'hff67_6981, 32'hfb3b_4c01, 32'hff67_6981};
   localparam logic [3:0][31:0] double_max = {32'h05f5_e0ff, 32'h05f5_e0ff, 32'h04c4_b3ff, 32'h0098_967f};

   // Sequencer states
   typedef enum logic [0:0] {
      st_idle    = 1'b0,
      st_convert = 1'b1
   } state_type;

   // Condition flags of one conversion
   typedef struct packed {
      logic negative;
      logic equal;
      logic error_flag;
   } flags_type;

   // Outcome of one conversion
   typedef struct packed {
      flags_type   flags;
      logic        write;
      logic [15:0] hi;
      logic [15:0] lo;
   } conv_result_type;

endpackage
`default_nettype wire

//--- hdl/signed_bcd_binary_converter.sv
// Signed BCD to binary and binary to signed BCD converter with a Wishbone register slave
// Functional notes
// - Opcode 470 converts one BCD word, 472 converts a two-word BCD value.
// - Error when format selector exceeds 3; error cleared when nothing is wrong.
// - BCD source: format 2 top digit A-E, format 3 top digit B-E is error.
// - BCD source: any non-decimal digit below the top digit, one word or two, is an error.
// - After BCD to binary, equal set when whole result is zero.
// - After BCD to binary, negative follows bit 15 of upper or single word.
// - Single format 0: -999..999 maps to FC19..FFFF and 0000..03E7.
// - Single format 1: -7999..7999 maps to E0C1..FFFF and 0000 upward.
// - Single format 2: accepts -999 up to 9999.
// - Single format 3: accepts -1999 up to 9999, negatives give F831..FFFF.
// - Double format 0: plus or minus 9999999, maximum 0098967F.
// - Double format 1: plus or minus 79999999, maximum 04C4B3FF.
// - Double format 2: -9999999 up to 99999999, maximum 05F5E0FF.
// - Double format 3: down to -19999999, which is FECED301.
// - Two-word operations: second word is upper half, both source and result.
// - Single binary to BCD accepts only the per-format window, emits signed BCD.
// - Double binary to BCD accepts only the per-format window, emits two BCD words.
// - Binary to BCD: source outside the format window is an error.
// - Binary to BCD format 3: negative when top result digit is A or F.
// - Negative zero counts as zero and raises no error.
`default_nettype none
module signed_bcd_binary_converter
   import sbcd_conv_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             done_o,
   output logic             error_flag_o,
   output logic             equal_o,
   output logic             negative_o
);

   // Nibble is a decimal digit
   function automatic logic digit_ok(input logic [3:0] d);
      return d <= 4'h9;
   endfunction

   // Eight packed BCD digits to binary, digits assumed valid
   function automatic logic [31:0] bcd_to_bin(input logic [31:0] bcd);
      logic [31:0] acc;
      acc = '0;
      for (int k = 7; k >= 0; k--) begin
         acc = (acc << 3) + (acc << 1) + {28'h0, bcd[4*k +: 4]};
      end
      return acc;
   endfunction

   // Binary magnitude to eight packed BCD digits, shift-and-add-three
   function automatic logic [31:0] bin_to_bcd(input logic [31:0] bin);
      logic [31:0] r;
      r = '0;
      for (int i = 31; i >= 0; i--) begin
         for (int k = 0; k < 8; k++) begin
            if (r[4*k +: 4] >= 4'h5) begin
               r[4*k +: 4] = r[4*k +: 4] + 4'h3;
            end
         end
         r = {r[30:0], bin[i]};
      end
      return r;
   endfunction

   // Byte-lane merge of a 16-bit register write; only the two low lanes exist
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [15:0] wd, input logic [3:0] sel);
      return {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Software visible state
   logic [15:0]     opcode_q, opcode_d;
   logic [15:0]     format_q, format_d;
   logic [15:0]     src_lo_q, src_lo_d;
   logic [15:0]     src_hi_q, src_hi_d;
   logic [15:0]     res_lo_q, res_lo_d;
   logic [15:0]     res_hi_q, res_hi_d;
   flags_type       flags_q, flags_d;
   logic            done_q, done_d;
   state_type       state_q, state_d;
   logic            ack_q, ack_d;
   logic [31:0]     dat_q, dat_d;
   conv_result_type conv;

   // Bus strobes; writes land on the edge where the master sees ack
   logic bus_req;
   logic wr_now;
   logic start_wr;
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign wr_now   = bus_req & wb_we_i & ack_q;
   assign start_wr = wr_now & (wb_adr_i == adr_start) & wb_sel_i[0] & wb_dat_i[0];

   // Conversion datapath, purely combinational from the held operands
   always_comb begin
      logic        single;
      logic        bad_fmt;
      logic        err;
      logic        neg;
      logic [1:0]  fmt;
      logic [3:0]  top;
      logic [3:0]  top_mag;
      logic [31:0] body;
      logic [31:0] mag;
      logic [31:0] val;
      logic [31:0] bcd;
      logic [31:0] lo_lim;
      logic [31:0] hi_lim;
      single  = 1'b0;
      bad_fmt = 1'b0;
      err     = 1'b0;
      neg     = 1'b0;
      fmt     = format_q[1:0];
      top     = 4'h0;
      top_mag = 4'h0;
      body    = '0;
      mag     = '0;
      val     = '0;
      bcd     = '0;
      lo_lim  = '0;
      hi_lim  = '0;
      conv    = '0;
      bad_fmt = format_q > format_max;
      if (opcode_q == op_bcd_to_bin_single || opcode_q == op_bcd_to_bin_double) begin
         single = opcode_q == op_bcd_to_bin_single;
         // Upper word is the high half of a two-word source
         top  = single ? src_lo_q[15:12] : src_hi_q[15:12];
         body = single ? {20'h0, src_lo_q[11:0]} : {4'h0, src_hi_q[11:0], src_lo_q};
         for (int k = 0; k < 8; k++) begin
            if (!digit_ok(body[4*k +: 4])) begin
               err = 1'b1;
            end
         end
         // Top digit carries sign and, in some formats, a magnitude digit
         case (fmt)
            2'h0: begin
               neg = top == 4'hf;
               err = err | (top != 4'hf && top != 4'h0);
            end
            2'h1: begin
               neg     = top[3];
               top_mag = {1'b0, top[2:0]};
            end
            2'h2: begin
               neg     = top == 4'hf;
               err     = err | (top >= 4'ha && top <= 4'he);
               top_mag = neg ? 4'h0 : top;
            end
            default: begin
               neg     = top == 4'hf || top == 4'ha;
               err     = err | (top >= 4'hb && top <= 4'he);
               top_mag = top == 4'ha ? 4'h1 : (neg ? 4'h0 : top);
            end
         endcase
         if (single) begin
            body[15:12] = top_mag;
         end else begin
            body[31:28] = top_mag;
         end
         mag = bcd_to_bin(body);
         val = neg ? (32'h0 - mag) : mag; // Minus zero folds to zero
         conv.lo = val[15:0];
         conv.hi = single ? word_reset : val[31:16];
         conv.flags.equal    = single ? (val[15:0] == 16'h0) : (val == 32'h0);
         conv.flags.negative = single ? val[15] : val[31];
      end else if (opcode_q == op_bin_to_bcd_single || opcode_q == op_bin_to_bcd_double) begin
         single = opcode_q == op_bin_to_bcd_single;
         val    = single ? {{16{src_lo_q[15]}}, src_lo_q} : {src_hi_q, src_lo_q};
         lo_lim = single ? single_min[fmt] : double_min[fmt];
         hi_lim = single ? single_max[fmt] : double_max[fmt];
         neg    = val[31];
         // Window check on the signed source
         err = neg ? ($signed(val) < $signed(lo_lim)) : ($signed(val) > $signed(hi_lim));
         mag = neg ? (32'h0 - val) : val;
         bcd = bin_to_bcd(mag);
         top = single ? bcd[15:12] : bcd[31:28];
         if (neg) begin
            case (fmt)
               2'h1:    top = top | 4'h8;
               2'h3:    top = top == 4'h1 ? 4'ha : 4'hf;
               default: top = 4'hf;
            endcase
         end
         if (single) begin
            bcd[15:12] = top;
            bcd[31:16] = '0;
         end else begin
            bcd[31:28] = top;
         end
         conv.lo             = bcd[15:0];
         conv.hi             = bcd[31:16];
         conv.flags.equal    = bcd == 32'h0;
         conv.flags.negative = neg;
      end else begin
         err = 1'b1; // Unknown operation code is refused like a bad format
      end
      // An error suppresses the write and every flag but error
      conv.flags.error_flag = err | bad_fmt;
      conv.write            = !conv.flags.error_flag;
      if (conv.flags.error_flag) begin
         conv.flags.negative = 1'b0;
         conv.flags.equal    = 1'b0;
      end
   end

   // Sequencer: a start write launches one conversion, result lands one cycle later
   always_comb begin
      state_d  = state_q;
      res_lo_d = res_lo_q;
      res_hi_d = res_hi_q;
      flags_d  = flags_q;
      done_d   = done_q;
      case (state_q)
         st_idle: begin
            if (start_wr) begin
               state_d = st_convert;
               done_d  = 1'b0;
            end
         end
         st_convert: begin
            state_d = st_idle;
            flags_d = conv.flags;
            done_d  = 1'b1; // Set wins: no clear can reach here in this state
            if (conv.write) begin
               res_lo_d = conv.lo;
               res_hi_d = conv.hi;
            end
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_q  <= st_idle;
         res_lo_q <= word_reset;
         res_hi_q <= word_reset;
         flags_q  <= '0;
         done_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         res_lo_q <= res_lo_d;
         res_hi_q <= res_hi_d;
         flags_q  <= flags_d;
         done_q   <= done_d;
      end
   end

   // Operand registers honour the two low byte lanes; frozen while converting
   always_comb begin
      logic        lock;
      lock     = state_q == st_convert;
      opcode_d = opcode_q;
      format_d = format_q;
      src_lo_d = src_lo_q;
      src_hi_d = src_hi_q;
      if (wr_now && !lock) begin
         case (wb_adr_i)
            adr_opcode: opcode_d = lane_merge(opcode_q, wb_dat_i[15:0], wb_sel_i);
            adr_format: format_d = lane_merge(format_q, wb_dat_i[15:0], wb_sel_i);
            adr_src_lo: src_lo_d = lane_merge(src_lo_q, wb_dat_i[15:0], wb_sel_i);
            adr_src_hi: src_hi_d = lane_merge(src_hi_q, wb_dat_i[15:0], wb_sel_i);
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         opcode_q <= word_reset;
         format_q <= word_reset;
         src_lo_q <= word_reset;
         src_hi_q <= word_reset;
      end else begin
         opcode_q <= opcode_d;
         format_q <= format_d;
         src_lo_q <= src_lo_d;
         src_hi_q <= src_hi_d;
      end
   end

   // Bus answer: ack one cycle after the request, dropped the next; unmapped reads give zero
   always_comb begin
      ack_d = bus_req & ~ack_q;
      dat_d = dat_q;
      if (bus_req && !ack_q) begin
         case (wb_adr_i)
            adr_opcode: dat_d = {16'h0, opcode_q};
            adr_format: dat_d = {16'h0, format_q};
            adr_src_lo: dat_d = {16'h0, src_lo_q};
            adr_src_hi: dat_d = {16'h0, src_hi_q};
            adr_res_lo: dat_d = {16'h0, res_lo_q};
            adr_res_hi: dat_d = {16'h0, res_hi_q};
            adr_status: begin
               dat_d                = bus_reset;
               dat_d[sts_done_bit]  = done_q;
               dat_d[sts_error_bit] = flags_q.error_flag;
               dat_d[sts_equal_bit] = flags_q.equal;
               dat_d[sts_neg_bit]   = flags_q.negative;
               dat_d[sts_busy_bit]  = state_q == st_convert;
            end
            default: dat_d = bus_reset;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ack_q <= 1'b0;
         dat_q <= bus_reset;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   // Outputs straight from flops
   assign wb_ack_o     = ack_q;
   assign wb_dat_o     = dat_q;
   assign done_o       = done_q;
   assign error_flag_o = flags_q.error_flag;
   assign equal_o      = flags_q.equal;
   assign negative_o   = flags_q.negative;

endmodule
`default_nettype wire

//--- verification/sequencer_model.sv
// Sequencer model: issues Wishbone classic cycles into the converter
`default_nettype none
module sequencer_model (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   output logic             hung_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'hff;
      sel_o = 4'h0;
      dat_o = 32'hffff_ffff;
      hung_o = 1'b0;
   end

   // One held request, released after the acknowledging edge or after 40 edges without ack
   task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] s,
                       output logic [31:0] rd);
      int n;
      n = 0;
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= wr;
      adr_o <= adr;
      sel_o <= s;
      dat_o <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_i !== 1'b1 && n < 40);
      // Only a wait that ended without ack is a hang
      if (ack_i !== 1'b1) begin
         hung_o <= 1'b1;
      end
      rd = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      sel_o <= 4'h0;
      // Released lines show the inverse, so no stale value looks valid
      adr_o <= ~adr;
      dat_o <= ~wd;
      @(posedge clk_i);
   endtask

   // Write with chosen byte lanes
   task automatic wr_lane(input logic [7:0] adr, input logic [15:0] wd, input logic [3:0] s);
      logic [31:0] d;
      xfer(1'b1, adr, {16'h0000, wd}, s, d);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [15:0] wd);
      wr_lane(adr, wd, 4'h3);
   endtask

   task automatic rd(input logic [7:0] adr, output logic [31:0] d);
      xfer(1'b0, adr, 32'h0000_0000, 4'h3, d);
   endtask
endmodule
`default_nettype wire

//--- verification/signed_bcd_binary_converter_props.sv
// Checker for bus timing and flags of the signed BCD converter
`default_nettype none
module signed_bcd_binary_converter_props
   import sbcd_conv_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        done_o,
   input wire logic        error_flag_o,
   input wire logic        equal_o,
   input wire logic        negative_o
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   // Acknowledged start write launches a conversion
   logic go;
   assign go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == adr_start;

   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_done_timing: assert property (go |=> !done_o ##1 done_o)
      else $error("done not one cycle after start");
   a_done_holds: assert property (done_o && !go |=> done_o)
      else $error("done dropped without start");
   a_error_alone: assert property (error_flag_o |-> !equal_o && !negative_o)
      else $error("flags raised beside error");
   a_flags_settle: assert property (!$rose(done_o) |-> $stable({error_flag_o, equal_o, negative_o}))
      else $error("flags moved without done");
   a_status_view: assert property (wb_ack_o && !wb_we_i && wb_adr_i == adr_status
      |-> wb_dat_o[3:0] == {negative_o, equal_o, error_flag_o, done_o})
      else $error("status differs from flag pins");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read half not zero");

   c_start: cover property (go);
   c_error: cover property ($rose(error_flag_o));
   c_negative: cover property ($rose(done_o) && negative_o);
endmodule

bind signed_bcd_binary_converter signed_bcd_binary_converter_props i_signed_bcd_binary_converter_props (
   .clk_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .done_o, .error_flag_o, .equal_o, .negative_o);
`default_nettype wire

//--- verification/signed_bcd_binary_converter_bench.sv
// Self-checking bench for the signed BCD converter
`default_nettype none
module signed_bcd_binary_converter_bench
   import sbcd_conv_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // Row: opcode, format, source hi/lo, result hi/lo, flags {error, equal, negative}
   typedef struct packed {
      logic [15:0] op;
      logic [15:0] fmt;
      logic [15:0] hi;
      logic [15:0] lo;
      logic [15:0] ehi;
      logic [15:0] elo;
      logic [3:0]  f;
   } row_type;

   logic        clk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        cyc, stb, we, ack, done_o, error_flag_o, equal_o, negative_o, hung;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   int          miscompares = 0;
   int          n_checks = 0;
   // Error rows leave the kept result in force
   row_type     rows [22] = '{
      100'h01d6_0000_0000_f999_0000_fc19_1, 100'h01d6_0000_0000_0999_0000_03e7_0,
      100'h01d6_0001_0000_f999_0000_e0c1_1, 100'h01d6_0002_0000_9999_0000_270f_0,
      100'h01d6_0003_0000_a999_0000_f831_1, 100'h01d6_0003_0000_b000_0000_0000_4,
      100'h01d6_0002_0000_a000_0000_0000_4, 100'h01d6_0000_0000_09a9_0000_0000_4,
      100'h01d6_0004_0000_0001_0000_0000_4, 100'h01d6_0000_0000_f000_0000_0000_2,
      100'h01d8_0000_f999_9999_ff67_6981_1, 100'h01d8_0001_7999_9999_04c4_b3ff_0,
      100'h01d8_0002_9999_9999_05f5_e0ff_0, 100'h01d8_0003_a999_9999_fece_d301_1,
      100'h01d8_0000_0000_00a0_0000_0000_4, 100'h01d7_0003_0000_f831_0000_a999_1,
      100'h01d7_0003_0000_2710_0000_0000_4, 100'h01d7_0000_0000_0000_0000_0000_2,
      100'h01d9_0003_fece_d300_0000_0000_4, 100'h01d7_0001_0000_e0c1_0000_f999_1,
      100'h01d9_0003_fece_d301_a999_9999_1, 100'h01d5_0000_0000_0001_0000_0000_4};

   always #5 clk_i = ~clk_i;

   signed_bcd_binary_converter i_signed_bcd_binary_converter (.clk_i(clk_i), .reset_i(reset_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .done_o(done_o), .error_flag_o(error_flag_o),
      .equal_o(equal_o), .negative_o(negative_o));
   sequencer_model i_sequencer_model (.clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .hung_o(hung));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // A stuck bus cycle ends the run
   always @(posedge hung) begin
      miscompares++;
      results();
   end

   initial begin
      row_type     r;
      logic [31:0] d;
      logic [15:0] last_hi, last_lo;
      int          n;
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      chk("pins after reset", 32'h0, {done_o, error_flag_o, equal_o, negative_o});
      i_sequencer_model.rd(adr_status, d);
      chk("status after reset", 32'h0, d);
      last_hi = 16'h0000;
      last_lo = 16'h0000;
      for (int i = 0; i < 22; i++) begin
         r = rows[i];
         i_sequencer_model.wr(adr_opcode, r.op);
         i_sequencer_model.wr(adr_format, r.fmt);
         i_sequencer_model.wr(adr_src_lo, r.lo);
         i_sequencer_model.wr(adr_src_hi, r.hi);
         i_sequencer_model.wr(adr_start, 16'h0001);
         n = 0;
         while (done_o !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
         end
         if (n >= 8) begin
            miscompares++;
            results();
         end
         if (r.f[2] == 1'b0) begin
            last_hi = r.ehi;
            last_lo = r.elo;
         end
         i_sequencer_model.rd(adr_res_lo, d);
         chk("res_lo", {16'h0000, last_lo}, d);
         i_sequencer_model.rd(adr_res_hi, d);
         chk("res_hi", {16'h0000, last_hi}, d);
         i_sequencer_model.rd(adr_status, d);
         chk("status", {28'h0, r.f[0], r.f[1], r.f[2], 1'b1}, d);
         chk("flag pins", {29'h0, r.f[2:0]}, {error_flag_o, equal_o, negative_o});
         $display("row %0d finished", i);
      end
      // Read-only result, unmapped place and start register
      i_sequencer_model.wr(adr_res_lo, 16'h1234);
      i_sequencer_model.rd(adr_res_lo, d);
      chk("res_lo read-only", {16'h0000, last_lo}, d);
      i_sequencer_model.wr(8'h20, 16'hffff);
      i_sequencer_model.rd(8'h20, d);
      chk("unmapped", 32'h0, d);
      i_sequencer_model.rd(adr_start, d);
      chk("start reads", 32'h0, d);
      // Each byte lane lands on its own
      i_sequencer_model.wr_lane(adr_format, 16'hab12, 4'h1);
      i_sequencer_model.rd(adr_format, d);
      chk("format low lane", 32'h0000_0012, d);
      i_sequencer_model.wr_lane(adr_format, 16'h34cd, 4'h2);
      i_sequencer_model.rd(adr_format, d);
      chk("format high lane", 32'h0000_3412, d);
      $display("register access test finished");
      // Reset in mid-run clears kept state
      reset_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      chk("pins after second reset", 32'h0, {done_o, error_flag_o, equal_o, negative_o});
      i_sequencer_model.rd(adr_res_hi, d);
      chk("res_hi after second reset", 32'h0, d);
      i_sequencer_model.rd(adr_format, d);
      chk("format after second reset", 32'h0, d);
      $display("second reset test finished");
      results();
   end
endmodule
`default_nettype wire
